// [verilog/pwm_pkg.sv]
// Shared constants for the pulse-width generator
package pwm_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] HIGH_PHASE_OFS = 4'h0;
    localparam logic [3:0] LOW_PHASE_OFS = 4'h4;
    localparam logic [3:0] CONFIG_OFS = 4'h8;
    localparam int LEN_W = 16;
    localparam logic [15:0] HIGH_PHASE_RST = 16'h0000;
    localparam logic [15:0] LOW_PHASE_RST = 16'hFFFF;
    localparam logic [6:0] CONFIG_RST = 7'h00;
    localparam int CFG_ENABLE_BIT = 0;
    localparam int CFG_SLOW_SEL_BIT = 1;
    localparam int CFG_INVERT_BIT = 2;
    localparam int CFG_PREDIV_LSB = 3;
    localparam int CFG_PREDIV_MSB = 6;
    // Source rates in kHz
    localparam int MCLK_KHZ = 20000;
    localparam int FAST_TICK_KHZ = 48000;
    localparam int SLOW_TICK_KHZ = 100;
    // Fast source exceeds mclk here, so it ticks every cycle
    localparam int FAST_DIV = (FAST_TICK_KHZ >= MCLK_KHZ) ? 1 : MCLK_KHZ / FAST_TICK_KHZ;
    localparam int SLOW_DIV = (MCLK_KHZ / SLOW_TICK_KHZ < 1) ? 1 : MCLK_KHZ / SLOW_TICK_KHZ;
    typedef enum logic [1:0] {ST_OFF, ST_ON_PHASE, ST_OFF_PHASE} phase_state_t;
endpackage

// [verilog/tick_divider.sv]
// Enable-pulse divider producing one pulse every DIV cycles
`timescale 1ns/1ps
`default_nettype none
module tick_divider
#(
    parameter int DIV = 200
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // Elaboration check: a zero or negative divide cannot be served
    if (DIV < 1) begin : g_bad_div
        $error("tick_divider: DIV must be at least 1");
    end

    // Wraps at LAST; held in reset while not running
    assign tick = run && (cnt_q == LAST);
    assign cnt_d = tick ? '0 : cnt_q + CW'(1);

    // Counter
    always_ff @(posedge mclk) begin
        if (rst || !run) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// [verilog/prescaler.sv]
// Divides the selected tick by the pre-divider value plus one
`timescale 1ns/1ps
`default_nettype none
module prescaler
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic src_tick,
    input wire logic [3:0] prediv,
    output logic tick
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic at_end;

    // Zero value bypasses: every source tick passes
    assign at_end = (cnt_q >= prediv);
    assign tick = run && src_tick && at_end;
    assign cnt_d = at_end ? 4'h0 : cnt_q + 4'h1;

    // Counts source ticks
    always_ff @(posedge mclk) begin
        if (rst || !run) begin
            cnt_q <= 4'h0;
        end else if (src_tick) begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// [verilog/pwm_output_generator.sv]
// Pulse-width generator with register port and phase counter
//
// Contract
// - Low-phase value n gives n+1 ticks of off time; resets to FFFF.
// - Low-phase value zero holds the output full on.
// - Pre-divider divides the selected source by value plus one.
// - Pre-divider zero passes every source tick to the counter.
// - Invert bit set makes the on state drive low; resets clear.
// - Source-select one picks the slow tick, zero the fast tick.
// - Clearing enable resets counters and forces the off state.
// - While disabled the output sits at the inactive level.
// - Phase-length registers ignore enable and stay readable and writable.
// - Disabled generator stops the counter logic to save power.
// - High-phase value n gives n+1 ticks of on time.
// - High zero with low nonzero holds the output full off.
// - New lengths wait in holding registers until all bytes land and the off phase ends; full on or disabled takes them at once.
// - Fast source is 48 MHz, slow source 100 kHz; the fast tick here runs at mclk, 20 MHz.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_generator
import pwm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wbe,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic pwm_out
);
    // Active and holding phase lengths
    logic [15:0] high_len_q;
    logic [15:0] low_len_q;
    logic [15:0] hold_high_q;
    logic [15:0] hold_low_q;
    logic [3:0] hold_full_q;
    logic [6:0] cfg_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    phase_state_t state_q;
    phase_state_t state_d;
    logic [31:0] rdata_q;
    logic out_q;

    // Decode
    logic wr_high;
    logic wr_low;
    logic wr_cfg;
    logic enable;
    logic invert;
    logic slow_sel;
    logic [3:0] prediv;
    logic fast_tick;
    logic slow_tick;
    logic src_tick;
    logic tick;
    logic full_on;
    logic full_off;
    logic [3:0] hold_full_d;
    logic [3:0] hold_set;
    logic hold_ready;
    logic low_done;
    logic do_load;
    logic on_level;
    logic [31:0] rd_mux;

    // Register select, shared by write and read decode
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    logic sel_high;
    logic sel_low;
    logic sel_cfg;

    // Offset match, one wire per register
    assign sel_high = addr_hit(addr, ADDR_W'(HIGH_PHASE_OFS));
    assign sel_low = addr_hit(addr, ADDR_W'(LOW_PHASE_OFS));
    assign sel_cfg = addr_hit(addr, ADDR_W'(CONFIG_OFS));

    // Write strobes per register; unmapped writes fall through
    assign wr_high = wr && sel_high;
    assign wr_low = wr && sel_low;
    assign wr_cfg = wr && sel_cfg;

    // Configuration fields
    assign enable = cfg_q[CFG_ENABLE_BIT];
    assign invert = cfg_q[CFG_INVERT_BIT];
    assign slow_sel = cfg_q[CFG_SLOW_SEL_BIT];
    assign prediv = cfg_q[CFG_PREDIV_MSB:CFG_PREDIV_LSB];

    // Tick sources, idle while disabled
    tick_divider #(.DIV(FAST_DIV)) u_fast (
        .mclk(mclk),
        .rst(rst),
        .run(enable && !slow_sel),
        .tick(fast_tick)
    );
    tick_divider #(.DIV(SLOW_DIV)) u_slow (
        .mclk(mclk),
        .rst(rst),
        .run(enable && slow_sel),
        .tick(slow_tick)
    );
    assign src_tick = slow_sel ? slow_tick : fast_tick;

    prescaler u_pre (
        .mclk(mclk),
        .rst(rst),
        .run(enable),
        .src_tick(src_tick),
        .prediv(prediv),
        .tick(tick)
    );

    // Special cases of the active lengths
    assign full_on = (low_len_q == 16'h0000);
    assign full_off = (high_len_q == 16'h0000) && !full_on;

    // Byte tracking of the holding registers
    // Lanes written this cycle; bits 1:0 high length, 3:2 low length
    assign hold_set = (wr_high ? {2'b00, wbe[1:0]} : 4'h0)
        | (wr_low ? {wbe[1:0], 2'b00} : 4'h0);
    assign hold_full_d = hold_full_q | hold_set;
    assign hold_ready = (hold_full_q == 4'hF);
    assign low_done = (state_q == ST_OFF_PHASE) && tick && (cnt_q == 16'h0000);
    assign do_load = hold_ready && (full_on || low_done || !enable);

    // Phase sequencer
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (!enable || full_on || full_off) begin
            state_d = ST_OFF;
            cnt_d = 16'h0000;
        end else if (state_q == ST_OFF) begin
            state_d = ST_ON_PHASE;
            cnt_d = high_len_q;
        end else if (tick) begin
            if (cnt_q != 16'h0000) begin
                cnt_d = cnt_q - 16'h0001;
            end else if (state_q == ST_ON_PHASE) begin
                state_d = ST_OFF_PHASE;
                cnt_d = low_len_q;
            end else begin
                state_d = ST_ON_PHASE;
                cnt_d = do_load ? hold_high_q : high_len_q;
            end
        end
    end

    // On level follows invert off level while disabled
    assign on_level = enable && (full_on || state_d == ST_ON_PHASE);
    assign pwm_out = out_q;

    // Read decode, reserved bits zero
    // Reads return the active lengths, never the holding copies
    assign rd_mux = sel_high ? {16'h0000, high_len_q} :
                    sel_low ? {16'h0000, low_len_q} :
                    sel_cfg ? {25'h0000000, cfg_q} : 32'h00000000;
    assign rdata = rdata_q;

    // Configuration register
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_q <= CONFIG_RST;
        end else if (wr_cfg && wbe[0]) begin
            cfg_q <= wdata[6:0];
        end
    end

    // Holding registers, per byte lane
    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_high_q <= HIGH_PHASE_RST;
            hold_low_q <= LOW_PHASE_RST;
        end else begin
            if (wr_high && wbe[0]) hold_high_q[7:0] <= wdata[7:0];
            if (wr_high && wbe[1]) hold_high_q[15:8] <= wdata[15:8];
            if (wr_low && wbe[0]) hold_low_q[7:0] <= wdata[7:0];
            if (wr_low && wbe[1]) hold_low_q[15:8] <= wdata[15:8];
        end
    end

    // Transfer to active registers; marks holding empty
    always_ff @(posedge mclk) begin
        if (rst) begin
            high_len_q <= HIGH_PHASE_RST;
            low_len_q <= LOW_PHASE_RST;
            hold_full_q <= 4'h0;
        end else if (do_load) begin
            high_len_q <= hold_high_q;
            low_len_q <= hold_low_q;
            hold_full_q <= hold_set; // Bytes landing now stay pending
        end else begin
            hold_full_q <= hold_full_d;
        end
    end

    // Sequencer state
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= ST_OFF;
            cnt_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Output pin, registered so the pin never glitches
    always_ff @(posedge mclk) begin
        if (rst) begin
            out_q <= 1'b0;
        end else begin
            out_q <= on_level ^ invert;
        end
    end

    // Read data, standing only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rd ? rd_mux : 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// [tb/pwm_sva.sv]
// Port assertions for the pulse-width generator
`timescale 1ns/1ps
`default_nettype none
module pwm_sva
import pwm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wbe,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic pwm_out
);
    logic [6:0] cfg_q;
    // Decoded shadow fields
    wire logic en = cfg_q[CFG_ENABLE_BIT];
    wire logic inv = cfg_q[CFG_INVERT_BIT];
    wire logic mapped = addr == HIGH_PHASE_OFS || addr == LOW_PHASE_OFS || addr == CONFIG_OFS;
    // Shadow copy of the configuration word
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_q <= CONFIG_RST;
        end else if (wr && addr == CONFIG_OFS && wbe[0]) begin
            cfg_q <= wdata[6:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_read_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero when idle");
    chk_unmapped_zero: assert property ($past(rd) && !$past(mapped) |-> rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_reserved_zero: assert property ($past(rd) |-> rdata[31:16] == 16'h0 && ($past(addr) != CONFIG_OFS || rdata[15:7] == 9'h0))
        else $error("reserved bits not zero");
    chk_config_read: assert property ($past(rd) && $past(addr) == CONFIG_OFS |-> rdata[6:0] == $past(cfg_q))
        else $error("config read mismatch");
    chk_reset_idle: assert property ($fell(rst) |-> pwm_out == 1'b0 && rdata == 32'h0)
        else $error("outputs not idle after reset");
    chk_off_level: assert property ((!en && $stable(inv)) [*3] |-> pwm_out == inv)
        else $error("disabled pin not at inactive level");
    chk_disable_quick: assert property ($fell(en) |-> ##[1:3] pwm_out == inv)
        else $error("pin slow to go inactive");
    chk_off_steady: assert property ((!en && $stable(inv)) [*4] |-> $stable(pwm_out))
        else $error("pin moved while disabled");
    cov_enable: cover property ($rose(en));
    cov_toggle: cover property (en && $changed(pwm_out));
    cov_cfg_read: cover property ($past(rd) && $past(addr) == CONFIG_OFS);
endmodule
`default_nettype wire

// [tb/pwm_load.sv]
// Load on the output pin: measures each level run in cycles
`timescale 1ns/1ps
`default_nettype none
module pwm_load
(
    input wire logic mclk,
    input wire logic pin,
    output logic run_done,
    output logic run_lvl,
    output logic [31:0] run_len
);
    logic lvl_q;
    logic [31:0] cnt_q;
    // A level change closes the run that just ended
    always_ff @(posedge mclk) begin
        run_done <= pin !== lvl_q;
        lvl_q <= pin;
        if (pin !== lvl_q) begin
            run_lvl <= lvl_q;
            run_len <= cnt_q;
            cnt_q <= 32'h1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule
`default_nettype wire

// [tb/pwm_output_generator_bench.sv]
// Self-checking bench for the pulse-width generator
`timescale 1ns/1ps
`default_nettype none
module pwm_output_generator_bench;
import pwm_pkg::*;
    logic mclk, rst, wr, rd, rd_d, pin, run_done, run_lvl;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata, run_len, e;
    logic [3:0] wbe;
    logic [31:0] rq[$];
    logic [32:0] pq[$];
    int miscompares, samples_checked, h, l, p, inv, slow, div, k;
    pwm_output_generator dut (.mclk, .rst, .addr, .wdata, .wbe, .wr, .rd, .rdata, .pwm_out(pin));
    pwm_load load (.mclk, .pin, .run_done, .run_lvl, .run_len);
    // Clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wreg(logic [3:0] a, logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        wbe <= 4'hF;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rreg(logic [3:0] a, logic [31:0] x);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        rq.push_back(x);
        @(posedge mclk);
        rd <= 1'b0;
    endtask
    task automatic drain(int n);
        for (k = 0; k < n && pq.size() > 0; k++) @(posedge mclk);
        if (pq.size() > 0) begin
            $display("timeout waiting for pin runs");
            miscompares++;
            end_sim();
        end
    endtask
    always @(posedge mclk) rd_d <= rd;
    // Compare read data and finished pin runs with the oldest notes
    always @(negedge mclk) begin
        if (rd_d === 1'b1) begin
            e = rq.pop_front();
            check("rdata", rdata, e);
        end
        if (run_done === 1'b1 && pq.size() > 0 && pq[0][32] === run_lvl) begin
            e = pq.pop_front();
            check("run", run_len, e);
        end
    end
    initial begin
        {rst, wr, rd, addr, wdata, wbe} = {1'b1, 42'h0};
        void'($urandom(99));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rreg(HIGH_PHASE_OFS, {16'h0, HIGH_PHASE_RST});
        rreg(LOW_PHASE_OFS, {16'h0, LOW_PHASE_RST});
        rreg(CONFIG_OFS, 32'h0);
        rreg(4'hC, 32'h0);
        $display("test reset values done");
        // Toggling: fast undivided, fast divided inverted, slow
        for (int t = 0; t < 3; t++) begin
            h = $urandom_range(4, 1);
            l = $urandom_range(4, 1);
            p = (t == 1) ? $urandom_range(3, 1) : 0;
            inv = t % 2;
            slow = t / 2;
            div = slow ? SLOW_DIV : FAST_DIV;
            wreg(CONFIG_OFS, 32'h0);
            wreg(HIGH_PHASE_OFS, h);
            wreg(LOW_PHASE_OFS, l);
            rreg(HIGH_PHASE_OFS, h);
            rreg(LOW_PHASE_OFS, l);
            wreg(CONFIG_OFS, {p[3:0], inv[0], slow[0], 1'b1});
            rreg(CONFIG_OFS, {p[3:0], inv[0], slow[0], 1'b1});
            repeat (2 * (h + l + 2) * (p + 1) * div) @(posedge mclk);
            pq.push_back({~inv[0], 32'((h + 1) * (p + 1) * div)});
            pq.push_back({inv[0], 32'((l + 1) * (p + 1) * div)});
            pq.push_back({~inv[0], 32'((h + 1) * (p + 1) * div)});
            drain(8 * (h + l + 2) * (p + 1) * div);
            $display("test toggling %0d done", t);
        end
        // Full on, then full off taken at once from full on
        wreg(CONFIG_OFS, 32'h5);
        wreg(HIGH_PHASE_OFS, 32'h2);
        wreg(LOW_PHASE_OFS, 32'h0);
        repeat (50) @(posedge mclk);
        check("pin", pin, 32'h0);
        wreg(HIGH_PHASE_OFS, 32'h0);
        wreg(LOW_PHASE_OFS, 32'h3);
        repeat (20) @(posedge mclk);
        check("pin", pin, 32'h1);
        wreg(CONFIG_OFS, 32'h0);
        repeat (3) @(posedge mclk);
        check("pin", pin, 32'h0);
        rreg(LOW_PHASE_OFS, 32'h3);
        // Half-written lengths stay pending until all four bytes land
        wreg(HIGH_PHASE_OFS, 32'h7);
        rreg(HIGH_PHASE_OFS, 32'h0);
        wreg(LOW_PHASE_OFS, 32'h5);
        rreg(HIGH_PHASE_OFS, 32'h7);
        rreg(LOW_PHASE_OFS, 32'h5);
        repeat (3) @(posedge mclk);
        $display("test full on and off done");
        end_sim();
    end
endmodule
bind pwm_output_generator pwm_sva chk (.mclk, .rst, .addr, .wdata, .wbe, .wr, .rd, .rdata, .pwm_out);
`default_nettype wire
